// >>> hw/poc_pll_out.sv
// pll output counters, phase taps, coarse start delay and output routing
// assumes apb master on pclk; ref pin comes from outside the domain, gpio from the fabric on pclk
//
// Local design decisions: register access over APB and the register offsets.
`timescale 1ns/1ps

// Function
// - four compensation modes, each keeping divide, phase and duty features
// - full compensation only with dedicated clock input pins as source
// - source synchronous mode keeps data and clock phase at io registers
// - no compensation mode: outputs lead or lag, internal clocks aligned
// - normal mode aligns internal clocks to input pin, external out delayed
// - zero delay mode aligns external out; negative pin unusable single-ended
// - only first counter drives dedicated external output directly
// - one single-ended or differential output; negative pin is inverse
// - adc clock only from first counter of first or third pll
// - no spread-spectrum generation or detection; tracking only
// - each counter has separate high and low counts in vco cycles
// - duty step equals fifty percent over the division value; counters here give 100%/div, whole vco periods only
// - dynamic shifts move taps only, unlimited, one scan clock each
// - any counter or feedback counter selects one of eight taps
// - coarse shift delays start by start count minus one vco periods
// - dedicated output pins serve as general io when unused; here only the positive pin does, the negative pin is held off
// - division 1..512 at fifty percent duty, else 1..256; counters here have no bypass, so no division below 2
// - pll reset clears counters, outputs and lock, then relocks
// - output rate is input times feedback over prescale times post-scale
module poc_pll_out #(
  parameter int PLL_INDEX  = 1,
  parameter int LOCK_COUNT = poc_pkg::LOCK_EDGES
) (
  input  wire logic                   pclk,
  input  wire logic                   presetn,
  input  wire logic                   psel,
  input  wire logic                   penable,
  input  wire logic                   pwrite,
  input  wire logic [7:0]             paddr,
  input  wire logic [31:0]            pwdata,
  output logic      [31:0]            prdata,
  output logic                        pready,
  output logic                        pslverr,
  input  wire logic                   ref_clk_pin,
  input  wire logic                   gpio_out,
  input  wire logic                   gpio_oe,
  output logic      [4:0]             global_clock_network,
  output poc_pkg::poc_ext_pins_t      ext_pins,
  output logic                        adc_clk,
  output logic                        locked,
  output poc_pkg::poc_mode_t          comp_mode,
  output logic                        full_comp
);
  import poc_pkg::*;

  initial begin
    if (PLL_INDEX < 1 || PLL_INDEX > 4) $error("pll index out of range");
    if (LOCK_COUNT < 1 || LOCK_COUNT > 65535) $error("lock count out of range");
  end

  // effective count: zero encodes 256
  function automatic logic [8:0] eff(input logic [7:0] v);
    return (v == 8'h00) ? 9'h100 : {1'b0, v};
  endfunction : eff

  // division legality per counter
  function automatic logic cfg_ok(input poc_cnt_cfg_t c);
    logic [9:0] d;
    d = 10'(eff(c.high)) + 10'(eff(c.low));
    if (c.high == c.low) return d <= 10'(LIMIT_50);
    return d <= 10'(LIMIT_OTHER);
  endfunction : cfg_ok

  typedef enum logic [1:0] {ST_IDLE, ST_WAIT, ST_APPLY} poc_step_t;

  logic [7:0]         ctrl_ff;
  logic [7:0]         pre_ff;
  poc_cnt_cfg_t       cfg_ff  [NUM_CNT];
  logic [2:0]         tap_ff  [NUM_CNT];
  logic [8:0]         cnt_ff  [NUM_CNT];
  logic [8:0]         dly_ff  [NUM_CNT];
  logic               out_ff  [NUM_CNT];
  logic               hi_ff   [NUM_CNT];
  logic [2:0]         phase_ff;
  logic [1:0]         ref_sync_ff;
  logic               ref_prev_ff;
  logic [7:0]         pre_cnt_ff;
  logic               m_prev_ff;
  logic               fb_seen_ff;
  logic [15:0]        lock_cnt_ff;
  logic               locked_ff;
  logic               run_ff;
  poc_step_t          step_ff;
  logic [2:0]         step_sel_ff;
  logic               step_up_ff;
  logic [7:0]         scan_cnt_ff;
  logic [31:0]        prdata_ff;
  logic [4:0]         gcn_ff;
  poc_ext_pins_t      ext_ff;
  logic               adc_ff;

  logic               wr_en;
  logic               rd_en;
  logic               addr_ok;
  logic               pll_rst;
  logic               pfd_ref;
  logic               m_rise;
  logic               cfg_err;
  logic               neg_err;
  logic               scan_tick;
  poc_mode_t          mode;
  logic [31:0]        nxt_prdata;

  assign mode    = poc_mode_t'(ctrl_ff[CTRL_MODE_LSB +: 2]);
  assign pll_rst = ctrl_ff[CTRL_ARESET];

  // apb decode; zero wait states, unmapped or misaligned gives pslverr
  assign addr_ok = (paddr[1:0] == 2'b00) && (paddr <= OFS_CNTN);
  assign wr_en   = psel && penable && pwrite && addr_ok;
  assign rd_en   = psel && penable && !pwrite;
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !addr_ok;

  // control, prescale and counter setting writes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_ff <= CTRL_RESET;
      pre_ff  <= 8'h01;
      for (int i = 0; i < NUM_CNT; i++) cfg_ff[i] <= CNT_RESET;
    end else if (wr_en) begin
      if (paddr == OFS_CTRL) ctrl_ff <= pwdata[7:0];
      if (paddr == OFS_PRE) pre_ff <= pwdata[7:0];
      for (int i = 0; i < NUM_CNT; i++) begin
        if (paddr == OFS_CNT0 + 8'(4 * i)) cfg_ff[i] <= poc_cnt_cfg_t'(pwdata[27:0]);
      end
    end
  end

  // a single setting covers the combined divider; checked against the range
  always_comb begin
    cfg_err = 1'b0;
    for (int i = 0; i < NUM_CNT; i++) begin
      if (!cfg_ok(cfg_ff[i])) cfg_err = 1'b1;
    end
  end

  // register read mux
  always_comb begin
    nxt_prdata = 32'h0000_0000;
    unique case (1'b1)
      paddr == OFS_CTRL: nxt_prdata = {24'h00_0000, ctrl_ff};
      paddr == OFS_PRE:  nxt_prdata = {24'h00_0000, pre_ff};
      paddr == OFS_STEP: nxt_prdata = {28'h000_0000, step_up_ff, step_sel_ff};
      paddr == OFS_STAT: begin
        nxt_prdata[STAT_LOCKED]  = locked_ff;
        nxt_prdata[STAT_BUSY]    = (step_ff != ST_IDLE);
        nxt_prdata[STAT_CFG_ERR] = cfg_err;
        nxt_prdata[STAT_NEG_ERR] = neg_err;
        nxt_prdata[STAT_FULLCMP] = full_comp;
      end
      default: begin
        for (int i = 0; i < NUM_CNT; i++) begin
          if (paddr == OFS_CNT0 + 8'(4 * i)) nxt_prdata = {4'h0, cfg_ff[i]};
        end
      end
    endcase
  end

  // read data registered so prdata comes from a flop during the access
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) prdata_ff <= 32'h0000_0000;
    else if (psel && !penable) prdata_ff <= nxt_prdata;
  end
  assign prdata = rd_en ? prdata_ff : 32'h0000_0000;

  // vco model: each pclk is one of eight taps, eight per vco period
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) phase_ff <= 3'h0;
    else phase_ff <= phase_ff + 3'h1;
  end

  // common start: all counters leave reset on the same vco period
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) run_ff <= 1'b0;
    else if (pll_rst) run_ff <= 1'b0;
    else if (phase_ff == 3'(NUM_TAPS - 1)) run_ff <= 1'b1;
  end

  // scan clock divider: one enable pulse per scan period
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) scan_cnt_ff <= 8'h00;
    else if (scan_tick) scan_cnt_ff <= 8'h00;
    else scan_cnt_ff <= scan_cnt_ff + 8'h01;
  end
  assign scan_tick = (scan_cnt_ff == 8'(SCAN_CYC - 1));

  // dynamic phase step: request, wait for scan tick, then apply once
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      step_ff     <= ST_IDLE;
      step_sel_ff <= 3'h0;
      step_up_ff  <= 1'b0;
    end else begin
      unique case (step_ff)
        ST_IDLE: begin
          // writes while busy are dropped; software polls the busy bit
          if (wr_en && paddr == OFS_STEP && pwdata[2:0] < 3'(NUM_CNT)) begin
            step_sel_ff <= pwdata[STEP_SEL_LSB +: 3];
            step_up_ff  <= pwdata[STEP_UP];
            step_ff     <= ST_WAIT;
          end
        end
        ST_WAIT:  if (scan_tick) step_ff <= ST_APPLY;
        ST_APPLY: step_ff <= ST_IDLE;
        default:  step_ff <= ST_IDLE;
      endcase
    end
  end

  // pending tap: only taps move dynamically, with wrap in either direction
  logic [2:0] tap_pend_ff [NUM_CNT];
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < NUM_CNT; i++) tap_pend_ff[i] <= 3'h0;
    end else begin
      for (int i = 0; i < NUM_CNT; i++) begin
        if (wr_en && paddr == OFS_CNT0 + 8'(4 * i)) tap_pend_ff[i] <= pwdata[27:25];
        else if (step_ff == ST_APPLY && step_sel_ff == 3'(i)) begin
          tap_pend_ff[i] <= step_up_ff ? tap_pend_ff[i] + 3'h1
                                       : tap_pend_ff[i] - 3'h1;
        end
      end
    end
  end

  // post-scale and feedback counters, each ticking on its own tap
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < NUM_CNT; i++) begin
        tap_ff[i] <= 3'h0;
        cnt_ff[i] <= 9'h000;
        dly_ff[i] <= 9'h000;
        out_ff[i] <= 1'b0;
        hi_ff[i]  <= 1'b0;
      end
    end else begin
      for (int i = 0; i < NUM_CNT; i++) begin
        if (!run_ff) begin
          // held: output low, start delay reloaded for a common start
          tap_ff[i] <= tap_pend_ff[i];
          cnt_ff[i] <= 9'h000;
          dly_ff[i] <= cfg_ff[i].start - 9'h001;
          out_ff[i] <= 1'b0;
          hi_ff[i]  <= 1'b0;
        end else if (phase_ff == tap_ff[i]) begin
          if (dly_ff[i] != 9'h000) begin
            dly_ff[i] <= dly_ff[i] - 9'h001;
          end else if (!hi_ff[i] && cnt_ff[i] == 9'h000 && tap_ff[i] != tap_pend_ff[i]) begin
            // boundary with a new tap: move first and rise on its next tick,
            // so only the low time stretches and no high pulse is cut short
            tap_ff[i] <= tap_pend_ff[i];
          end else if (!hi_ff[i] && cnt_ff[i] == 9'h000) begin
            out_ff[i] <= 1'b1;
            hi_ff[i]  <= 1'b1;
            cnt_ff[i] <= eff(cfg_ff[i].high) - 9'h001;
          end else if (cnt_ff[i] != 9'h000) begin
            cnt_ff[i] <= cnt_ff[i] - 9'h001;
          end else begin
            // high phase done: low count reloads; whole vco periods give 100%/div duty steps
            out_ff[i] <= 1'b0;
            hi_ff[i]  <= 1'b0;
            cnt_ff[i] <= eff(cfg_ff[i].low) - 9'h001;
          end
        end
      end
    end
  end

  // reference pin: two flops before use, then prescale by n
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ref_sync_ff <= 2'b00;
      ref_prev_ff <= 1'b0;
    end else begin
      ref_sync_ff <= {ref_sync_ff[0], ref_clk_pin};
      ref_prev_ff <= ref_sync_ff[1];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) pre_cnt_ff <= 8'h00;
    else if (pll_rst) pre_cnt_ff <= 8'h00;
    else if (ref_sync_ff[1] && !ref_prev_ff) begin
      pre_cnt_ff <= (pre_cnt_ff + 8'h01 >= pre_ff) ? 8'h00 : pre_cnt_ff + 8'h01;
    end
  end
  assign pfd_ref = ref_sync_ff[1] && !ref_prev_ff && (pre_cnt_ff == 8'h00);

  // feedback edge from the m counter closes the loop model
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) m_prev_ff <= 1'b0;
    else m_prev_ff <= out_ff[M_IDX];
  end
  assign m_rise = out_ff[M_IDX] && !m_prev_ff;

  // lock: enough prescaled reference edges with feedback alive between them
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fb_seen_ff  <= 1'b0;
      lock_cnt_ff <= 16'h0000;
      locked_ff   <= 1'b0;
    end else if (pll_rst || !run_ff) begin
      fb_seen_ff  <= 1'b0;
      lock_cnt_ff <= 16'h0000;
      locked_ff   <= 1'b0;
    end else begin
      // with the detector gated the loop drifts; lock held as last state
      if (pfd_ref && ctrl_ff[CTRL_PFD_EN]) begin
        fb_seen_ff <= m_rise;
        if (!fb_seen_ff && !m_rise) lock_cnt_ff <= 16'h0000;
        else if (lock_cnt_ff != 16'(LOCK_COUNT)) lock_cnt_ff <= lock_cnt_ff + 16'h0001;
      end else if (m_rise) begin
        fb_seen_ff <= 1'b1;
      end
      locked_ff <= (lock_cnt_ff == 16'(LOCK_COUNT));
    end
  end

  // compensation: full only from dedicated pins, none in no-comp mode
  assign full_comp = ctrl_ff[CTRL_DED_SRC] && (mode != POC_NO_COMP);
  assign comp_mode = mode;
  // spread-spectrum: no generator and no detector exist here by design

  // negative pin single-ended in zero delay mode is not allowed
  assign neg_err = (mode == POC_ZERO_DELAY_BUFFER) && ctrl_ff[CTRL_EXT_EN]
                   && !ctrl_ff[CTRL_DIFF];

  // output routing, registered so pins see no decode glitches
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gcn_ff <= 5'h00;
      ext_ff <= '{p_out: 1'b0, p_oe: 1'b0, n_out: 1'b0, n_oe: 1'b0};
      adc_ff <= 1'b0;
    end else begin
      for (int i = 0; i < 5; i++) gcn_ff[i] <= out_ff[i] && !pll_rst;
      if (ctrl_ff[CTRL_EXT_EN]) begin
        ext_ff.p_out <= out_ff[0] && !pll_rst;
        ext_ff.p_oe  <= 1'b1;
        ext_ff.n_out <= !(out_ff[0] && !pll_rst);
        ext_ff.n_oe  <= ctrl_ff[CTRL_DIFF];
      end else begin
        ext_ff.p_out <= gpio_out;
        ext_ff.p_oe  <= gpio_oe;
        ext_ff.n_out <= 1'b0;
        ext_ff.n_oe  <= 1'b0;
      end
      adc_ff <= (PLL_INDEX == 1 || PLL_INDEX == 3) && ctrl_ff[CTRL_ADC_EN]
                && out_ff[0] && !pll_rst;
    end
  end

  assign global_clock_network = gcn_ff;
  assign ext_pins             = ext_ff;
  assign adc_clk              = adc_ff;
  assign locked               = locked_ff;

endmodule : poc_pll_out

// >>> pkg/poc_pkg.sv
// constants and types for the pll output counter and phase block
// assumes a single 40 mhz pclk; the vco is modelled as eight pclk taps
package poc_pkg;

  // counters: five post-scale counters plus the feedback multiply counter
  localparam int NUM_CNT  = 6;
  localparam int M_IDX    = 5;
  localparam int NUM_TAPS = 8;

  // apb register byte offsets
  localparam logic [7:0] OFS_CTRL  = 8'h00;
  localparam logic [7:0] OFS_STAT  = 8'h04;
  localparam logic [7:0] OFS_PRE   = 8'h08;
  localparam logic [7:0] OFS_STEP  = 8'h0C;
  localparam logic [7:0] OFS_CNT0  = 8'h10;
  localparam logic [7:0] OFS_CNTN  = 8'h24;

  // control register fields
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_ARESET   = 2;
  localparam int CTRL_PFD_EN   = 3;
  localparam int CTRL_EXT_EN   = 4;
  localparam int CTRL_DIFF     = 5;
  localparam int CTRL_ADC_EN   = 6;
  localparam int CTRL_DED_SRC  = 7;
  localparam logic [7:0] CTRL_RESET = 8'h08;

  // status register fields
  localparam int STAT_LOCKED  = 0;
  localparam int STAT_BUSY    = 1;
  localparam int STAT_CFG_ERR = 2;
  localparam int STAT_NEG_ERR = 3;
  localparam int STAT_FULLCMP = 4;

  // phase step register fields
  localparam int STEP_SEL_LSB = 0;
  localparam int STEP_UP      = 3;

  // timing
  localparam int CLK_MHZ      = 40;
  localparam int SCAN_NS      = 100;
  localparam int SCAN_CYC     = (SCAN_NS * CLK_MHZ) / 1000;
  localparam int LOCK_EDGES   = 16;
  localparam int LIMIT_50     = 512;
  localparam int LIMIT_OTHER  = 256;

  typedef enum logic [1:0] {
    POC_SRC_SYNC,
    POC_NO_COMP,
    POC_NORMAL,
    POC_ZERO_DELAY_BUFFER
  } poc_mode_t;

  // one counter setting; a count of zero stands for 256
  typedef struct packed {
    logic [2:0] tap;
    logic [8:0] start;
    logic [7:0] low;
    logic [7:0] high;
  } poc_cnt_cfg_t;

  localparam poc_cnt_cfg_t CNT_RESET = '{tap: 3'h0, start: 9'h001, low: 8'h01, high: 8'h01};

  // pin group toward the dedicated external clock output pair
  typedef struct packed {
    logic p_out;
    logic p_oe;
    logic n_out;
    logic n_oe;
  } poc_ext_pins_t;

endpackage : poc_pkg

// >>> verif/poc_fabric_model.sv
// fabric side model: reference oscillator and general io register
// assumes pclk is the fabric clock; the oscillator runs free
`timescale 1ns/1ps
module poc_fabric_model #(
  parameter int REF_HALF = 20
) (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic io_val,
  input  wire logic io_en,
  output logic      ref_clk_pin,
  output logic      gpio_out,
  output logic      gpio_oe
);
  int ref_cnt = 0;
  initial ref_clk_pin = 1'b0;
  // steady unmodulated reference, so tracking is never in doubt
  always @(posedge pclk) begin
    ref_cnt <= (ref_cnt == REF_HALF - 1) ? 0 : ref_cnt + 1;
    if (ref_cnt == REF_HALF - 1) ref_clk_pin <= ~ref_clk_pin;
  end
  // fabric io register feeding the dedicated pin when it is free
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gpio_out <= 1'b0;
      gpio_oe  <= 1'b0;
    end else begin
      gpio_out <= io_val;
      gpio_oe  <= io_en;
    end
  end
endmodule : poc_fabric_model

// >>> verif/poc_out_asserts.sv
// port checker for the pll output block, bound onto its top module
// assumes one pclk domain and the register map of poc_pkg
`timescale 1ns/1ps
module poc_out_chk #(
  parameter int PLL_INDEX = 1
) (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pslverr,
  input wire logic [4:0]  global_clock_network,
  input wire poc_pkg::poc_ext_pins_t ext_pins,
  input wire logic        adc_clk,
  input wire logic        locked,
  input wire poc_pkg::poc_mode_t comp_mode,
  input wire logic        full_comp
);
  import poc_pkg::*;
  logic ctl_wr;
  logic ctl_rst_ff;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  assign ctl_wr = psel && penable && pwrite && paddr == OFS_CTRL;
  // software reset level; a pulse cut short by it is legal
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctl_rst_ff <= 1'b0;
    end else if (ctl_wr) begin
      ctl_rst_ff <= pwdata[CTRL_ARESET];
    end
  end
  // bus answer, then output relations
  slverr_map_a: assert property (psel && penable |->
    pslverr == (paddr > OFS_CNTN || paddr[1:0] != 2'h0)) else $error("slave error wrong");
  rdata_idle_a: assert property (!(psel && penable && !pwrite) |-> prdata == 32'h0)
    else $error("read data outside read");
  mode_follow_a: assert property (ctl_wr |=> comp_mode == $past(pwdata[1:0]))
    else $error("mode not taken");
  full_comp_a: assert property (full_comp |-> comp_mode != POC_NO_COMP)
    else $error("full compensation in wrong mode");
  ext_direct_a: assert property (ext_pins.n_oe |-> ext_pins.p_out == global_clock_network[0])
    else $error("external out not first counter");
  ext_inverse_a: assert property (ext_pins.n_oe |-> ext_pins.p_oe && ext_pins.n_out != ext_pins.p_out)
    else $error("negative pin not inverse");
  adc_source_a: assert property (adc_clk |->
    (PLL_INDEX == 1 || PLL_INDEX == 3) && global_clock_network[0]) else $error("adc clock source");
  high_pulse_a: assert property (disable iff (!presetn || ctl_rst_ff)
    $rose(global_clock_network[0]) |-> global_clock_network[0] [*8]) else $error("runt pulse");
  areset_clear_a: assert property (ctl_wr && pwdata[CTRL_ARESET] |->
    ##[1:4] (!locked && global_clock_network == 5'h00 && !adc_clk)) else $error("reset left state");
endmodule : poc_out_chk

bind poc_pll_out poc_out_chk #(.PLL_INDEX(PLL_INDEX)) i_chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pslverr(pslverr),
  .global_clock_network(global_clock_network), .ext_pins(ext_pins), .adc_clk(adc_clk),
  .locked(locked), .comp_mode(comp_mode), .full_comp(full_comp)
);

// >>> verif/tb_pll_output_counter_phase.sv
// self-checking bench for the pll output block over apb
// assumes the fabric model above and a short lock count of two
`timescale 1ns/1ps
module tb_pll_output_counter_phase;
  import poc_pkg::*;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic io_val = 1'b0, io_en = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, seed = 32'h00001E68;
  logic pready, pslverr, ref_clk_pin, gpio_out, gpio_oe, adc_clk, locked, full_comp;
  logic [4:0] gcn;
  poc_ext_pins_t ext;
  poc_mode_t comp_mode;
  int err_count = 0, n_checks = 0, cyc = 0;
  int exp_reg [10];
  logic [31:0] cfg [6] = '{32'h00010503, 32'h00030202, 32'h00010202,
                           32'h06010202, 32'h00010202, 32'h00010101};

  poc_pll_out #(.PLL_INDEX(1), .LOCK_COUNT(2)) i_dut (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .ref_clk_pin(ref_clk_pin),
    .gpio_out(gpio_out), .gpio_oe(gpio_oe), .global_clock_network(gcn), .ext_pins(ext),
    .adc_clk(adc_clk), .locked(locked), .comp_mode(comp_mode), .full_comp(full_comp));
  poc_fabric_model #(.REF_HALF(20)) i_fab (.pclk(pclk), .presetn(presetn), .io_val(io_val),
    .io_en(io_en), .ref_clk_pin(ref_clk_pin), .gpio_out(gpio_out), .gpio_oe(gpio_oe));

  // 40 mhz clock and a cycle count for edge timing
  always #12.5 pclk = ~pclk;
  always @(posedge pclk) cyc <= cyc + 1;

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd

  // model of the counter range rule on one setting word
  function automatic logic cfg_bad(input logic [31:0] d);
    int h, l;
    h = (d[7:0] == 8'h00) ? 256 : int'(d[7:0]);
    l = (d[15:8] == 8'h00) ? 256 : int'(d[15:8]);
    return (h + l) > ((d[7:0] == d[15:8]) ? LIMIT_50 : LIMIT_OTHER);
  endfunction : cfg_bad

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t: %s got %h exp %h", $time, m, got, exp);
    end
  endtask : chk

  // one apb transfer; an idle cycle after it keeps strobes single-driven
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // only the watchdog ends a wait for the answer
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  // write, keeping the reference copy of each register
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
    if (a <= OFS_CNTN && a[1:0] == 2'h0 && a != OFS_STAT)
      exp_reg[a >> 2] = d & ((a >= OFS_CNT0) ? 32'h0FFFFFFF :
                             (a == OFS_STEP) ? 32'h0000000F : 32'h000000FF);
  endtask : wr

  task automatic rdc(input logic [7:0] a);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h0, r, e);
    chk(r, exp_reg[a >> 2], "readback");
    chk(e, 0, "slave error");
  endtask : rdc

  task automatic edg(input int k, input logic v, output int t);
    logic p;
    int n;
    n = 0;
    do begin
      p = gcn[k];
      @(posedge pclk);
      n++;
    end while (!(p === ~v && gcn[k] === v) && n < 300);
    t = cyc;
    if (n >= 300) chk(0, 1, "no clock edge");
  endtask : edg

  task automatic wait_lock();
    int n;
    n = 0;
    while (locked !== 1'b1 && n < 4000) begin
      @(posedge pclk);
      n++;
    end
    chk(locked, 1, "lock");
  endtask : wait_lock

  task automatic conclude();
    $display("checks %0d errors %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : conclude

  // watchdog well beyond the roughly six hundred cycles of the run
  initial begin
    repeat (40000) @(posedge pclk);
    err_count++;
    conclude();
  end

  initial begin
    int t1, t2, t3;
    logic [31:0] r, v;
    logic e;
    exp_reg = '{default: 32'(CNT_RESET)};
    exp_reg[0] = 32'(CTRL_RESET);
    exp_reg[2] = 1;
    exp_reg[3] = 0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    for (int i = 0; i < 10; i++) if (i != 1) rdc(8'(i * 4));
    // unmapped and misaligned places
    apb(1'b0, 8'h28, 32'h0, r, e);
    chk(r, 0, "unmapped read");
    chk(e, 1, "unmapped error");
    wr(8'h06, 32'hFFFFFFFF);
    rdc(OFS_CTRL);
    // lock, drop on software reset, relock
    wait_lock();
    apb(1'b0, OFS_STAT, 32'h0, r, e);
    chk(r[STAT_LOCKED], 1, "lock status");
    wr(OFS_CTRL, 32'h0000000C);
    repeat (4) @(posedge pclk);
    chk({locked, gcn}, 0, "reset clears");
    wr(OFS_CTRL, 32'h00000008);
    wait_lock();
    for (int m = 0; m < 8; m++) begin
      wr(OFS_CTRL, 32'(8 | (m & 3) | ((m >> 2) << 7)));
      chk(32'(comp_mode), m & 3, "mode");
      chk(full_comp, (m >> 2) && (m & 3) != 1, "full comp");
    end
    wr(OFS_CTRL, 32'h0000009B);
    apb(1'b0, OFS_STAT, 32'h0, r, e);
    chk(r[STAT_NEG_ERR], 1, "negative pin single-ended");
    chk(r[STAT_FULLCMP], 1, "full comp status");
    // random counter fields and prescale, read back whole
    for (int i = 2; i < 10; i++) if (i != 3) wr(8'(i * 4), rnd());
    for (int i = 2; i < 10; i++) rdc(8'(i * 4));
    v = 32'h0;
    for (int i = 4; i < 10; i++) v[0] = v[0] | cfg_bad(exp_reg[i]);
    apb(1'b0, OFS_STAT, 32'h0, r, e);
    chk(r[STAT_CFG_ERR], v[0], "range flag");
    wr(OFS_PRE, 32'h0);
    for (int i = 0; i < 6; i++) wr(OFS_CNT0 + 8'(i * 4), cfg[i]);
    apb(1'b0, OFS_STAT, 32'h0, r, e);
    chk(r[STAT_CFG_ERR], 0, "range flag clear");
    wr(OFS_CTRL, 32'h0000007C);
    wr(OFS_CTRL, 32'h00000078);
    edg(2, 1'b1, t1);
    edg(3, 1'b1, t2);
    edg(1, 1'b1, t3);
    chk(t2 - t1, 3, "tap offset");
    chk(t3 - t1, 16, "start delay");
    edg(0, 1'b1, t1);
    edg(0, 1'b0, t2);
    edg(0, 1'b1, t3);
    chk(t2 - t1, 24, "high time");
    chk(t3 - t2, 40, "low time");
    repeat (64) begin
      @(posedge pclk);
      chk({ext.p_out, ext.n_out, ext.p_oe, ext.n_oe, adc_clk},
          {gcn[0], ~gcn[0], 2'b11, gcn[0]}, "ext");
    end
    // one dynamic step up on counter two
    wr(OFS_STEP, 32'h0000000A);
    for (int n = 0; n < 10; n++) begin
      apb(1'b0, OFS_STAT, 32'h0, r, e);
      if (r[STAT_BUSY] === 1'b0) break;
    end
    chk(r[STAT_BUSY], 0, "step busy");
    rdc(OFS_STEP);
    repeat (64) @(posedge pclk);
    edg(4, 1'b1, t1);
    edg(2, 1'b1, t2);
    chk(t2 - t1, 1, "step shift");
    wr(OFS_CTRL, 32'h00000028);
    repeat (4) begin
      v = rnd();
      io_val <= v[0];
      io_en <= v[1];
      repeat (6) @(posedge pclk);
      chk({ext.p_out, ext.p_oe, ext.n_out, ext.n_oe}, {v[0], v[1], 2'b00}, "general io");
    end
    conclude();
  end
endmodule : tb_pll_output_counter_phase
